/* logic/rcbp_data_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module rcbp_data_reg (
   // clock and control
   input wire logic clk,
   input wire logic clk_en,
   input wire logic rst,
   // data
   input wire logic [rcbp_pkg::DATA_W-1:0] din,
   input wire logic layout_sel,
   input wire logic hold,
   output logic [rcbp_pkg::DATA_W-1:0] q
);

   typedef struct packed {
      logic [rcbp_pkg::DATA_W-1:0] q;
   } rcbp_dreg_s;

   rcbp_dreg_s state_reg;
   rcbp_dreg_s state_next;

   // ------------------------------------------------------------
   // capture
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (rst) begin
         state_next.q = rcbp_pkg::DATA_RST;
      end else if (!hold) begin
         // unused lanes forced low so they never toggle on the bus
         state_next.q = din & rcbp_pkg::layout_mask(layout_sel);
      end
      // hold keeps the old word
   end

   always_ff @(posedge clk) begin
      if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign q = state_reg.q;

endmodule

`default_nettype wire

/* logic/rcbp_par_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module rcbp_par_chk (
   // clock and control
   input wire logic clk,
   input wire logic clk_en,
   input wire logic rst,
   // link to the command path
   rcbp_chk_if.chk chk
);

   typedef struct packed {
      logic dpar;
      logic en1;
      logic en2;
      logic mism;
      logic err_n;
      logic err_oe;
      logic [rcbp_pkg::CNT_W-1:0] cnt;
   } rcbp_chk_s;

   rcbp_chk_s state_reg;
   rcbp_chk_s state_next;

   // ------------------------------------------------------------
   // three stage check: data word, late parity bit, error flag
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (rst) begin
         state_next.dpar = 1'b0;
         state_next.en1 = 1'b0;
         state_next.en2 = 1'b0;
         state_next.mism = 1'b0;
         state_next.err_n = rcbp_pkg::ERR_N_RST;
         state_next.err_oe = 1'b0;
         state_next.cnt = rcbp_pkg::CNT_ZERO;
      end else begin
         state_next.dpar = ^chk.word;
         state_next.en1 = chk.sel_any;
         // parity bit comes one edge after its data word
         state_next.mism = state_reg.dpar ^ chk.parity_bit;
         state_next.en2 = state_reg.en1;
         if (state_reg.en2 && state_reg.mism) begin
            state_next.err_n = 1'b0;
            state_next.cnt = rcbp_pkg::HOLD_AFTER_ERR;
         end else if (!state_reg.en2) begin
            // all selects high: flag frozen, a pending low is stretched
            if (!state_reg.err_n) begin
               state_next.cnt = rcbp_pkg::HOLD_CYC;
            end
         end else if (state_reg.cnt != rcbp_pkg::CNT_ZERO) begin
            state_next.err_n = 1'b0;
            state_next.cnt = state_reg.cnt - 2'h1;
         end else begin
            state_next.err_n = 1'b1;
         end
         state_next.err_oe = ~state_next.err_n;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign chk.err_n = state_reg.err_n;
   assign chk.err_oe = state_reg.err_oe;

endmodule

`default_nettype wire

/* logic/rcbp_top.sv */
`timescale 1ns/1ps
`default_nettype none

module rcbp_top (
   // clock and control
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CLK_EN,
   // configuration
   input wire logic LAYOUT_SEL,
   input wire logic SELECT_GATE_ENABLE,
   // command inputs
   input wire logic [rcbp_pkg::DATA_W-1:0] BUFFERED_IN,
   input wire logic [rcbp_pkg::ODT_W-1:0] TERMINATION_IN,
   input wire logic [rcbp_pkg::CKE_W-1:0] CLK_ENABLE_IN,
   input wire logic RANK_SELECT_ZERO_N,
   input wire logic RANK_SELECT_ONE_N,
   input wire logic RANK_SELECT_TWO_N,
   input wire logic RANK_SELECT_THREE_N,
   input wire logic PARITY_BIT_IN,
   // copy a outputs
   output logic [rcbp_pkg::DATA_W-1:0] BUFFERED_OUT_A,
   output logic [rcbp_pkg::ODT_W-1:0] TERMINATION_OUT_A,
   output logic [rcbp_pkg::CKE_W-1:0] CLK_ENABLE_OUT_A,
   output logic REDRIVEN_SELECT_ZERO_A,
   output logic REDRIVEN_SELECT_ONE_A,
   // copy b outputs
   output logic [rcbp_pkg::DATA_W-1:0] BUFFERED_OUT_B,
   output logic [rcbp_pkg::ODT_W-1:0] TERMINATION_OUT_B,
   output logic [rcbp_pkg::CKE_W-1:0] CLK_ENABLE_OUT_B,
   output logic REDRIVEN_SELECT_ZERO_B,
   output logic REDRIVEN_SELECT_ONE_B,
   // status
   output logic PARITY_ERROR_N,
   output logic PARITY_ERROR_OE,
   output logic LOW_POWER_STATE
);

   typedef struct packed {
      logic [rcbp_pkg::ODT_W-1:0] odt;
      logic [rcbp_pkg::CKE_W-1:0] cke;
      logic cs0;
      logic cs1;
      logic low_power_state;
   } rcbp_ctl_s;

   rcbp_ctl_s state_reg;
   rcbp_ctl_s state_next;
   logic sel_any;
   logic data_hold;
   logic [rcbp_pkg::DATA_W-1:0] data_q;

   rcbp_chk_if chk_if ();

   // ------------------------------------------------------------
   // select decode
   // ------------------------------------------------------------
   assign sel_any = ~(RANK_SELECT_ZERO_N & RANK_SELECT_ONE_N
                     & RANK_SELECT_TWO_N & RANK_SELECT_THREE_N);
   assign data_hold = SELECT_GATE_ENABLE & ~sel_any;

   // ------------------------------------------------------------
   // unconditional control lanes
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (RST) begin
         state_next.odt = rcbp_pkg::ODT_RST;
         state_next.cke = rcbp_pkg::CKE_RST;
         state_next.cs0 = 1'b0;
         state_next.cs1 = 1'b0;
         state_next.low_power_state = 1'b0;
      end else begin
         // these never gate, the dram needs them in low-power mode
         state_next.odt = TERMINATION_IN;
         state_next.cke = CLK_ENABLE_IN;
         state_next.cs0 = RANK_SELECT_ZERO_N;
         state_next.cs1 = RANK_SELECT_ONE_N;
         state_next.low_power_state = data_hold;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (CLK_EN) begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // data path and parity check
   // ------------------------------------------------------------
   rcbp_data_reg u_data (
      .clk(SYS_CLK),
      .clk_en(CLK_EN),
      .rst(RST),
      .din(BUFFERED_IN),
      .layout_sel(LAYOUT_SEL),
      .hold(data_hold),
      .q(data_q)
   );

   // parity uses the masked raw word, not the held output
   assign chk_if.word = BUFFERED_IN & rcbp_pkg::layout_mask(LAYOUT_SEL);
   assign chk_if.sel_any = sel_any;
   assign chk_if.parity_bit = PARITY_BIT_IN;

   rcbp_par_chk u_chk (
      .clk(SYS_CLK),
      .clk_en(CLK_EN),
      .rst(RST),
      .chk(chk_if)
   );

   // ------------------------------------------------------------
   // outputs, both copies from the same flops
   // ------------------------------------------------------------
   assign BUFFERED_OUT_A = data_q;
   assign BUFFERED_OUT_B = data_q;
   assign TERMINATION_OUT_A = state_reg.odt;
   assign TERMINATION_OUT_B = state_reg.odt;
   assign CLK_ENABLE_OUT_A = state_reg.cke;
   assign CLK_ENABLE_OUT_B = state_reg.cke;
   assign REDRIVEN_SELECT_ZERO_A = state_reg.cs0;
   assign REDRIVEN_SELECT_ZERO_B = state_reg.cs0;
   assign REDRIVEN_SELECT_ONE_A = state_reg.cs1;
   assign REDRIVEN_SELECT_ONE_B = state_reg.cs1;
   assign PARITY_ERROR_N = chk_if.err_n;
   assign PARITY_ERROR_OE = chk_if.err_oe;
   assign LOW_POWER_STATE = state_reg.low_power_state;

endmodule

`default_nettype wire

/* pkg/rcbp_chk_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface rcbp_chk_if;
   logic [rcbp_pkg::DATA_W-1:0] word;
   logic sel_any;
   logic parity_bit;
   logic err_n;
   logic err_oe;

   modport top (output word, output sel_any, output parity_bit, input err_n, input err_oe);
   modport chk (input word, input sel_any, input parity_bit, output err_n, output err_oe);
endinterface

`default_nettype wire

/* pkg/rcbp_pkg.sv */
package rcbp_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int DATA_W = 28;
   localparam int ODT_W = 2;
   localparam int CKE_W = 2;
   localparam int CNT_W = 2;

   // ------------------------------------------------------------
   // layout masks, bit n of the pin numbering sits at index n-1
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] LAYOUT0_MASK = 28'h fff0f5f;
   localparam logic [DATA_W-1:0] LAYOUT1_MASK = 28'h faf0fff;

   // ------------------------------------------------------------
   // reset values and timing counts
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RST = 28'h 0000000;
   localparam logic [ODT_W-1:0] ODT_RST = 2'h 0;
   localparam logic [CKE_W-1:0] CKE_RST = 2'h 0;
   localparam logic ERR_N_RST = 1'h 1;
   localparam logic [CNT_W-1:0] HOLD_CYC = 2'h 2;
   localparam logic [CNT_W-1:0] HOLD_AFTER_ERR = 2'h 1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 2'h 0;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [DATA_W-1:0] layout_mask(input logic sel);
      layout_mask = sel ? LAYOUT1_MASK : LAYOUT0_MASK;
   endfunction

endpackage

/* verif/rcbp_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rcbp_ctrl_model (
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic layout_sel,
   // request
   input wire logic [27:0] word,
   input wire logic bad,
   // lines to the buffer
   output logic [27:0] data,
   output logic par
);
   assign data = word;
   // the bit trails its word by one edge; bad flips it on purpose
   always_ff @(posedge clk) begin
      if (rst) begin
         par <= 1'b0;
      end else begin
         par <= ^(word & (layout_sel ? rcbp_pkg::LAYOUT1_MASK : rcbp_pkg::LAYOUT0_MASK)) ^ bad;
      end
   end
endmodule
`default_nettype wire

/* verif/rcbp_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module rcbp_top_properties (
   // clock and control
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CLK_EN,
   input wire logic LAYOUT_SEL,
   input wire logic SELECT_GATE_ENABLE,
   // command inputs
   input wire logic [27:0] BUFFERED_IN,
   input wire logic [1:0] TERMINATION_IN,
   input wire logic RANK_SELECT_ZERO_N,
   input wire logic RANK_SELECT_ONE_N,
   input wire logic RANK_SELECT_TWO_N,
   input wire logic RANK_SELECT_THREE_N,
   input wire logic PARITY_BIT_IN,
   // outputs
   input wire logic [27:0] BUFFERED_OUT_A,
   input wire logic [1:0] TERMINATION_OUT_A,
   input wire logic REDRIVEN_SELECT_ZERO_A,
   input wire logic PARITY_ERROR_N,
   input wire logic PARITY_ERROR_OE,
   input wire logic LOW_POWER_STATE
);
   logic hi;
   logic [27:0] m;
   assign hi = RANK_SELECT_ZERO_N & RANK_SELECT_ONE_N & RANK_SELECT_TWO_N & RANK_SELECT_THREE_N;
   assign m = LAYOUT_SEL ? rcbp_pkg::LAYOUT1_MASK : rcbp_pkg::LAYOUT0_MASK;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST || !CLK_EN);
   // parity is judged on the edge after the word, when its bit arrives
   sequence s_bad;
      !hi ##1 (^($past(BUFFERED_IN) & m) ^ PARITY_BIT_IN);
   endsequence
   sequence s_idle;
      hi ##1 1'b1;
   endsequence
   a_data_capture:
      assert property (!(SELECT_GATE_ENABLE && hi) |=> BUFFERED_OUT_A == ($past(BUFFERED_IN) & m))
      else $error("data not captured");
   a_data_hold:
      assert property (SELECT_GATE_ENABLE && hi |=> $stable(BUFFERED_OUT_A)) else $error("data moved");
   a_ctl_capture:
      assert property (1'b1 |=> {TERMINATION_OUT_A, REDRIVEN_SELECT_ZERO_A} ==
         $past({TERMINATION_IN, RANK_SELECT_ZERO_N})) else $error("control not captured");
   a_low_power:
      assert property (1'b1 |=> LOW_POWER_STATE == $past(SELECT_GATE_ENABLE && hi))
      else $error("low power flag wrong");
   a_reset_clear:
      assert property (disable iff (1'b0) RST && CLK_EN |=> BUFFERED_OUT_A == 28'h0000000 &&
         PARITY_ERROR_N && !PARITY_ERROR_OE && !LOW_POWER_STATE) else $error("reset state wrong");
   a_err_detect:
      assert property (s_bad |-> ##2 !PARITY_ERROR_N) else $error("parity error missed");
   a_err_min_low:
      assert property ($fell(PARITY_ERROR_N) |=> !PARITY_ERROR_N) else $error("error too short");
   a_err_idle_hold:
      assert property (s_idle |-> ##2 $stable(PARITY_ERROR_N)) else $error("error moved when idle");
endmodule
`default_nettype wire

/* verif/rcbp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rcbp_top_tb;
   typedef struct packed {
      logic [33:0] bus;
      logic lps;
      logic err;
   } rcbp_exp_s;
   logic sys_clk, rst, lay, gate, bad, ce, err_exp;
   logic [27:0] word, held;
   logic [1:0] term, cke, low_left;
   logic [3:0] sel_n;
   logic [2:0] bad_h, en_h;
   logic [31:0] lfsr = 32'hdb52;
   wire [27:0] din, qa, qb;
   wire [5:0] ca, cb;
   wire par, err_n, err_oe, lps;
   rcbp_exp_s exp_q[$];
   rcbp_exp_s e, last;
   int errors = 0;
   int compares = 0;
   rcbp_ctrl_model rcbp_ctrl_model_i (.clk(sys_clk), .rst(rst), .layout_sel(lay), .word(word),
      .bad(bad), .data(din), .par(par));
   rcbp_top rcbp_top_i (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(ce), .LAYOUT_SEL(lay),
      .SELECT_GATE_ENABLE(gate), .BUFFERED_IN(din), .TERMINATION_IN(term), .CLK_ENABLE_IN(cke),
      .RANK_SELECT_ZERO_N(sel_n[0]), .RANK_SELECT_ONE_N(sel_n[1]), .RANK_SELECT_TWO_N(sel_n[2]),
      .RANK_SELECT_THREE_N(sel_n[3]), .PARITY_BIT_IN(par), .BUFFERED_OUT_A(qa),
      .TERMINATION_OUT_A(ca[5:4]), .CLK_ENABLE_OUT_A(ca[3:2]), .REDRIVEN_SELECT_ZERO_A(ca[0]),
      .REDRIVEN_SELECT_ONE_A(ca[1]), .BUFFERED_OUT_B(qb), .TERMINATION_OUT_B(cb[5:4]),
      .CLK_ENABLE_OUT_B(cb[3:2]), .REDRIVEN_SELECT_ZERO_B(cb[0]), .REDRIVEN_SELECT_ONE_B(cb[1]),
      .PARITY_ERROR_N(err_n), .PARITY_ERROR_OE(err_oe), .LOW_POWER_STATE(lps));
   function automatic logic [31:0] rnd(input logic [31:0] v);
      rnd = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk_bus(input string n, input logic [33:0] x, input logic [33:0] y);
      compares++;
      if (x !== y) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", n, x, y);
      end
   endtask
   task automatic chk_bit(input string n, input logic x, input logic y);
      compares++;
      if (x !== y) begin
         errors++;
         $display("unexpected %s: expected %b seen %b", n, x, y);
      end
   endtask
   task automatic stop_test();
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // one word per edge, expectation noted as it is sent
   task automatic step(input logic g, input logic [3:0] s, input logic b);
      logic h;
      @(negedge sys_clk);
      ce = 1'b1;
      lfsr = rnd(lfsr);
      word = lfsr[27:0];
      {term, cke} = lfsr[31:28];
      gate = g;
      sel_n = s;
      bad = b & ~&s;
      h = g & &s;
      if (!h) held = word & (lay ? rcbp_pkg::LAYOUT1_MASK : rcbp_pkg::LAYOUT0_MASK);
      bad_h = {bad_h[1:0], bad};
      en_h = {en_h[1:0], ~&s};
      // the flag answers the word two edges back, frozen while that word went unselected
      if (en_h[2]) begin
         if (bad_h[2]) begin
            low_left = 2'h2;
         end
         err_exp = (low_left == 2'h0);
         if (low_left != 2'h0) begin
            low_left = low_left - 2'h1;
         end
      end else if (!err_exp) begin
         // a low flag outlasts the unselected stretch by two edges
         low_left = 2'h2;
      end
      last = {held, term, cke, s[1:0], h, err_exp};
      exp_q.push_back(last);
   endtask
   // inputs held and enable low: the edge must leave every output as it was
   task automatic freeze();
      @(negedge sys_clk);
      ce = 1'b0;
      exp_q.push_back(last);
   endtask
   // last three words stay clean so no error is pending at idle
   task automatic run(input int n);
      logic [31:0] r;
      for (int i = n; i > 0; i--) begin
         r = rnd(lfsr);
         lfsr = r;
         if (i < n && r[12:10] == 3'h0) freeze();
         step(r[8], r[3:0] & ~(4'h1 << r[5:4]), i > 3 && r[7:6] == 2'h0);
      end
   endtask
   task automatic reset_to(input logic l);
      @(negedge sys_clk);
      rst = 1'b1;
      lay = l;
      {word, term, cke, gate, bad, held, bad_h, en_h, low_left} = '0;
      err_exp = 1'b1;
      ce = 1'b1;
      sel_n = 4'hf;
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
   endtask
   always @(posedge sys_clk) begin
      if (exp_q.size() > 0) begin
         #1;
         e = exp_q.pop_front();
         chk_bus("copy a", e.bus, {qa, ca});
         chk_bus("copy b", e.bus, {qb, cb});
         chk_bit("low power", e.lps, lps);
         chk_bit("error flag", e.err, err_n);
         chk_bit("error drive", ~e.err, err_oe);
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      rst = 1'b1;
      {lay, gate, bad, word, term, cke} = '0;
      ce = 1'b1;
      sel_n = 4'hf;
      for (int l = 0; l < 2; l++) begin
         reset_to(l[0]);
         run(120);
         step(1'b0, 4'he, 1'b1);
         repeat (4) step(1'b1, 4'hf, 1'b0);
         freeze();
         repeat (2) step(1'b0, 4'hf, 1'b0);
         run(20);
      end
      repeat (3) @(negedge sys_clk);
      stop_test();
   end
   initial begin
      #50000;
      errors++;
      stop_test();
   end
endmodule
bind rcbp_top rcbp_top_properties rcbp_top_properties_i (.*);
`default_nettype wire
